//--- design/rtb_pkg.sv
// rtb_pkg: register map, field positions, reset values and timing
// for the receiver tuning and type B framing block.
// assumes a 25 MHz hclk and a 13.56 MHz carrier (fc).
package rtb_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] RMT_IDX = 8'h1D;
  localparam logic [7:0] TBF_IDX = 8'h1E;
  localparam logic [7:0] CTL_IDX = 8'h20;
  localparam logic [7:0] IRQ_STAT_IDX = 8'h21;
  localparam logic [7:0] IRQ_MASK_IDX = 8'h22;
  localparam logic [7:0] STAT_IDX = 8'h23;

  localparam logic [7:0] RMT_RESET = 8'h00;
  localparam logic [7:0] TBF_RESET = 8'h00;
  localparam logic CTL_RESET = 1'b0;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
  // writable bits; reserved bits stay zero
  localparam logic [7:0] RMT_WMASK = 8'h7F;
  localparam logic [7:0] TBF_WMASK = 8'hDF;

  // receiver_manual_tuning fields
  localparam int RMT_FAST_BIT = 6;
  localparam int RMT_DLY_BIT = 5;
  localparam int RMT_PAR_BIT = 4;
  localparam int RMT_PLL_BIT = 3;
  localparam int RMT_MAN_BIT = 2;
  localparam int RMT_HPC_LSB = 0;
  // type_b_framing_config fields
  localparam int TBF_RXSOF_BIT = 7;
  localparam int TBF_RXEOF_BIT = 6;
  localparam int TBF_WIDTH_BIT = 4;
  localparam int TBF_NOSOF_BIT = 3;
  localparam int TBF_NOEOF_BIT = 2;
  localparam int TBF_EGT_LSB = 0;
  // own control and interrupt fields
  localparam int CTL_ADJ_BIT = 0;
  localparam int IRQ_IGN_BIT = 0;
  localparam int IRQ_PERR_BIT = 1;
  localparam int IRQ_DONE_BIT = 2;
  localparam int IRQ_W = 3;

  // timing: signal_output_pin delay of 128 carrier cycles, rounded up to hclk
  localparam int FC_KHZ = 13560;
  localparam int CLK_KHZ = 25000;
  localparam int SIGNAL_OUTPUT_PIN_DELAY_FC = 128;
  localparam int SIGNAL_OUTPUT_PIN_DELAY_CYC = (SIGNAL_OUTPUT_PIN_DELAY_FC * CLK_KHZ + FC_KHZ - 1) / FC_KHZ;
  // delimiter lengths in carrier cycles
  localparam int ETU_FC = 128;
  localparam int ADJ_FC = 8;
  localparam logic [11:0] SOF_LOW_MIN_FC = 12'(10 * ETU_FC);
  localparam logic [11:0] SOF_LOW_MAX_FC = 12'(11 * ETU_FC);
  localparam logic [11:0] SOF_HIGH_MIN_FC = 12'(2 * ETU_FC);
  localparam logic [11:0] SOF_HIGH_MAX_FC = 12'(3 * ETU_FC);
  localparam logic [11:0] EOF_LOW_MIN_FC = 12'(10 * ETU_FC);
  localparam logic [11:0] EOF_LOW_MAX_FC = 12'(11 * ETU_FC);
  localparam logic [11:0] SOF_LOW_ADJ_FC = 12'(11 * ETU_FC - ADJ_FC);
  localparam logic [11:0] SOF_HIGH_ADJ_FC = 12'(2 * ETU_FC + ADJ_FC);
  localparam logic [11:0] EOF_LOW_ADJ_FC = 12'(11 * ETU_FC - ADJ_FC);

  typedef enum logic [1:0] {
    RTB_RX_IDLE = 2'b00,
    RTB_RX_DATA = 2'b01,
    RTB_RX_DROP = 2'b10
  } rtb_rx_state_t;

  // register hit in the data phase of a mapped access
  function automatic logic rtb_hit(input logic act, input logic map,
                                   input logic [7:0] a, input logic [7:0] idx);
    return act && map && (a == idx);
  endfunction
endpackage

//--- design/rtb_delim_timing.sv
// rtb_delim_timing: type B start/end delimiter lengths and guard time
// for the transmitter, in carrier cycles.
// assumes configuration bits come from registers on hclk.
`timescale 1ns/100ps
module rtb_delim_timing (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic width,
  input wire logic adjust,
  input wire logic sof_sup,
  input wire logic eof_sup,
  input wire logic [1:0] egt,
  output logic [11:0] sof_low_fc,
  output logic [11:0] sof_high_fc,
  output logic [11:0] eof_low_fc,
  output logic sof_en,
  output logic eof_en,
  output logic [1:0] egt_bits
);
  logic [11:0] sof_low_nxt;
  logic [11:0] sof_high_nxt;
  logic [11:0] eof_low_nxt;

  // width=0 with adjust=1 is not a legal setting; minimum lengths used
  always_comb begin
    if (width && adjust) begin
      sof_low_nxt = rtb_pkg::SOF_LOW_ADJ_FC;
      sof_high_nxt = rtb_pkg::SOF_HIGH_ADJ_FC;
      eof_low_nxt = rtb_pkg::EOF_LOW_ADJ_FC;
    end else if (width) begin
      sof_low_nxt = rtb_pkg::SOF_LOW_MAX_FC;
      sof_high_nxt = rtb_pkg::SOF_HIGH_MAX_FC;
      eof_low_nxt = rtb_pkg::EOF_LOW_MAX_FC;
    end else begin
      sof_low_nxt = rtb_pkg::SOF_LOW_MIN_FC;
      sof_high_nxt = rtb_pkg::SOF_HIGH_MIN_FC;
      eof_low_nxt = rtb_pkg::EOF_LOW_MIN_FC;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sof_low_fc <= rtb_pkg::SOF_LOW_MIN_FC;
      sof_high_fc <= rtb_pkg::SOF_HIGH_MIN_FC;
      eof_low_fc <= rtb_pkg::EOF_LOW_MIN_FC;
      sof_en <= 1'b1;
      eof_en <= 1'b1;
      egt_bits <= 2'h0;
    end else begin
      sof_low_fc <= sof_low_nxt;
      sof_high_fc <= sof_high_nxt;
      eof_low_fc <= eof_low_nxt;
      sof_en <= !sof_sup;
      eof_en <= !eof_sup;
      egt_bits <= egt;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_adj_len;
    width && adjust |=> sof_low_fc == 12'h578 && sof_high_fc == 12'h108
      && eof_low_fc == 12'h578;
  endproperty
  a_adj_len: assert property (p_adj_len) else $error("adjusted delimiter length wrong");

  property p_max_len;
    width && !adjust |=> sof_low_fc == 12'h580 && eof_low_fc == 12'h580;
  endproperty
  a_max_len: assert property (p_max_len) else $error("maximum delimiter length wrong");

  property p_suppress;
    sof_sup && eof_sup |=> !sof_en && !eof_en;
  endproperty
  a_suppress: assert property (p_suppress) else $error("delimiter not suppressed");
endmodule // rtb_delim_timing

//--- design/rtb_top.sv
// rtb_top: AHB-Lite slave holding the receiver tuning and type B framing
// registers, the receive frame filter, signal_output_pin delay and interrupt.
// assumes one 25 MHz hclk; rx stream and signal_output_pin source come from hclk logic.
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/100ps
// Summary of operation
// - tuning bit 6 switches the miller-delay filter to fast mode.
// - tuning bit 5 delays the signal output pin by 128 carrier cycles.
// - tuning bit 4 turns parity generation and checking off.
// - tuning bit 3 widens the clock-recovery pll bandwidth.
// - tuning bit 2 low picks corner from rx mode, high uses the field.
// - corner codes 00..11 select 106, 212, 424, 848 kHz filters.
// - framing bit 7 set: streams without start-of-frame are ignored.
// - framing bit 7 clear: accept either, start-of-frame never stored.
// - framing bit 6 set: stream ending without end-of-frame is an error.
// - framing bit 6 clear: accept either, end-of-frame never stored.
// - width bit picks max or min delimiter lengths when adjust is 0.
// - width and adjust set: sof low 11 etu-8, high 2 etu+8 cycles.
// - width and adjust set: eof low 11 etu minus 8 carrier cycles.
// - suppress bits omit transmitted start- or end-of-frame.
// - guard time field gives 0 to 3 extra bits.
module rtb_top #(
  parameter int SIGNAL_OUTPUT_PIN_DLY = rtb_pkg::SIGNAL_OUTPUT_PIN_DELAY_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [1:0] rx_speed_code,
  input wire logic rx_begin,
  input wire logic rx_has_sof,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_finish,
  input wire logic rx_has_eof,
  input wire logic sig_out_src,
  output logic miller_filter_fast,
  output logic signal_output_pin_delay_enable,
  output logic parity_off,
  output logic wide_recovery_pll,
  output logic [1:0] highpass_corner_frequency,
  output logic signal_output_pin,
  output logic fifo_wr,
  output logic [7:0] fifo_data,
  output logic [11:0] sof_low_fc,
  output logic [11:0] sof_high_fc,
  output logic [11:0] eof_low_fc,
  output logic tx_start_frame_en,
  output logic tx_end_frame_en,
  output logic [1:0] tx_extra_guard_time,
  output logic irq
);
  logic ap_act_r, ap_write_r, ap_map_r, addr_take, wr_act, rd_act;
  logic wr_rmt, wr_tbf, wr_ctl, wr_stat, wr_mask;
  logic [7:0] ap_idx_r;
  logic [31:0] rdata_nxt;
  logic [7:0] rmt_r, tbf_r;
  logic ctl_adj_r;
  logic [rtb_pkg::IRQ_W-1:0] irq_stat_r, irq_stat_nxt, irq_mask_r, evt;
  rtb_pkg::rtb_rx_state_t rx_state_r, rx_state_nxt;
  logic sof_req, eof_req, ign_evt, perr_evt, done_evt;
  logic [SIGNAL_OUTPUT_PIN_DLY-1:0] sig_pipe_r;
  logic [1:0] hpc_nxt;

  assign addr_take = hsel && hready && htrans[1];

  // address phase capture; only whole-word aligned accesses are mapped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_act_r <= 1'b0;
      ap_write_r <= 1'b0;
      ap_map_r <= 1'b0;
      ap_idx_r <= 8'h00;
    end else begin
      ap_act_r <= addr_take;
      if (addr_take) begin
        ap_write_r <= hwrite;
        ap_map_r <= (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'b00);
        ap_idx_r <= haddr[9:2];
      end
    end
  end

  // one wait state so read data can come from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= !addr_take;
      hresp <= 1'b0;
    end
  end

  assign wr_act = ap_act_r && ap_write_r;
  assign wr_rmt = rtb_pkg::rtb_hit(wr_act, ap_map_r, ap_idx_r, rtb_pkg::RMT_IDX);
  assign wr_tbf = rtb_pkg::rtb_hit(wr_act, ap_map_r, ap_idx_r, rtb_pkg::TBF_IDX);
  assign wr_ctl = rtb_pkg::rtb_hit(wr_act, ap_map_r, ap_idx_r, rtb_pkg::CTL_IDX);
  assign wr_stat = rtb_pkg::rtb_hit(wr_act, ap_map_r, ap_idx_r, rtb_pkg::IRQ_STAT_IDX);
  assign wr_mask = rtb_pkg::rtb_hit(wr_act, ap_map_r, ap_idx_r, rtb_pkg::IRQ_MASK_IDX);
  assign rd_act = ap_act_r && !ap_write_r;

  // unmapped reads return zero
  always_comb begin
    rdata_nxt = 32'h00000000;
    if (ap_map_r) begin
      case (ap_idx_r)
        rtb_pkg::RMT_IDX: rdata_nxt = {24'h000000, rmt_r};
        rtb_pkg::TBF_IDX: rdata_nxt = {24'h000000, tbf_r};
        rtb_pkg::CTL_IDX: rdata_nxt = {31'h00000000, ctl_adj_r};
        rtb_pkg::IRQ_STAT_IDX: rdata_nxt = {29'h00000000, irq_stat_r};
        rtb_pkg::IRQ_MASK_IDX: rdata_nxt = {29'h00000000, irq_mask_r};
        rtb_pkg::STAT_IDX: rdata_nxt = {30'h00000000, rx_state_r};
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_act) begin
      hrdata <= rdata_nxt;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rmt_r <= rtb_pkg::RMT_RESET;
    end else if (wr_rmt) begin
      rmt_r <= hwdata[7:0] & rtb_pkg::RMT_WMASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tbf_r <= rtb_pkg::TBF_RESET;
    end else if (wr_tbf) begin
      tbf_r <= hwdata[7:0] & rtb_pkg::TBF_WMASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_adj_r <= rtb_pkg::CTL_RESET;
    end else if (wr_ctl) begin
      ctl_adj_r <= hwdata[rtb_pkg::CTL_ADJ_BIT];
    end
  end
  // manual corner only when asked; else follow the receive speed
  assign hpc_nxt = rmt_r[rtb_pkg::RMT_MAN_BIT] ? rmt_r[rtb_pkg::RMT_HPC_LSB +: 2]
                                               : rx_speed_code;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      miller_filter_fast <= 1'b0;
      signal_output_pin_delay_enable <= 1'b0;
      parity_off <= 1'b0;
      wide_recovery_pll <= 1'b0;
      highpass_corner_frequency <= 2'b00;
    end else begin
      miller_filter_fast <= rmt_r[rtb_pkg::RMT_FAST_BIT];
      signal_output_pin_delay_enable <= rmt_r[rtb_pkg::RMT_DLY_BIT];
      parity_off <= rmt_r[rtb_pkg::RMT_PAR_BIT];
      wide_recovery_pll <= rmt_r[rtb_pkg::RMT_PLL_BIT];
      highpass_corner_frequency <= hpc_nxt;
    end
  end

  // signal_output_pin delay line; flop cost traded for an exact, glitch-free delay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sig_pipe_r <= '0;
      signal_output_pin <= 1'b0;
    end else begin
      sig_pipe_r <= {sig_pipe_r[SIGNAL_OUTPUT_PIN_DLY-2:0], sig_out_src};
      if (rmt_r[rtb_pkg::RMT_DLY_BIT]) begin
        signal_output_pin <= sig_pipe_r[SIGNAL_OUTPUT_PIN_DLY-1];
      end else begin
        signal_output_pin <= sig_out_src;
      end
    end
  end
  // delimiters arrive as flags, never as bytes, so they are never stored
  assign sof_req = tbf_r[rtb_pkg::TBF_RXSOF_BIT];
  assign eof_req = tbf_r[rtb_pkg::TBF_RXEOF_BIT];
  assign ign_evt = (rx_state_r == rtb_pkg::RTB_RX_IDLE) && rx_begin && sof_req
                   && !rx_has_sof;
  assign perr_evt = (rx_state_r == rtb_pkg::RTB_RX_DATA) && rx_finish && eof_req
                    && !rx_has_eof;
  assign done_evt = (rx_state_r == rtb_pkg::RTB_RX_DATA) && rx_finish && !perr_evt;

  always_comb begin
    rx_state_nxt = rx_state_r;
    case (rx_state_r)
      rtb_pkg::RTB_RX_IDLE: begin
        if (rx_begin) begin
          rx_state_nxt = ign_evt ? rtb_pkg::RTB_RX_DROP
                                 : rtb_pkg::RTB_RX_DATA;
        end
      end
      rtb_pkg::RTB_RX_DATA: begin
        if (rx_finish) begin
          rx_state_nxt = rtb_pkg::RTB_RX_IDLE;
        end
      end
      rtb_pkg::RTB_RX_DROP: begin
        if (rx_finish) begin
          rx_state_nxt = rtb_pkg::RTB_RX_IDLE;
        end
      end
      default: rx_state_nxt = rtb_pkg::RTB_RX_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state_r <= rtb_pkg::RTB_RX_IDLE;
    end else begin
      rx_state_r <= rx_state_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fifo_wr <= 1'b0;
      fifo_data <= 8'h00;
    end else begin
      fifo_wr <= (rx_state_r == rtb_pkg::RTB_RX_DATA) && rx_byte_valid;
      if (rx_byte_valid) begin
        fifo_data <= rx_byte;
      end
    end
  end
  rtb_delim_timing u_delim (
    .hclk(hclk),
    .hresetn(hresetn),
    .width(tbf_r[rtb_pkg::TBF_WIDTH_BIT]),
    .adjust(ctl_adj_r),
    .sof_sup(tbf_r[rtb_pkg::TBF_NOSOF_BIT]),
    .eof_sup(tbf_r[rtb_pkg::TBF_NOEOF_BIT]),
    .egt(tbf_r[rtb_pkg::TBF_EGT_LSB +: 2]),
    .sof_low_fc(sof_low_fc),
    .sof_high_fc(sof_high_fc),
    .eof_low_fc(eof_low_fc),
    .sof_en(tx_start_frame_en),
    .eof_en(tx_end_frame_en),
    .egt_bits(tx_extra_guard_time)
  );
  assign evt = {done_evt, perr_evt, ign_evt};

  // a new event wins over a clear in the same cycle
  always_comb begin
    irq_stat_nxt = irq_stat_r;
    if (wr_stat) begin
      irq_stat_nxt = irq_stat_r & ~hwdata[rtb_pkg::IRQ_W-1:0];
    end
    irq_stat_nxt = irq_stat_nxt | evt;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_r <= rtb_pkg::IRQ_MASK_RESET;
    end else if (wr_mask) begin
      irq_mask_r <= hwdata[rtb_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  localparam int DLY_AGE_W = 10;
  logic [DLY_AGE_W-1:0] dly_age_r;
  // cycles since the signal_output_pin delay was last switched on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dly_age_r <= '0;
    end else if (!rmt_r[rtb_pkg::RMT_DLY_BIT]) begin
      dly_age_r <= '0;
    end else if (dly_age_r != '1) begin
      dly_age_r <= dly_age_r + 1'b1;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_fast;
    wr_rmt |=> ##1 miller_filter_fast == $past(hwdata[6], 2);
  endproperty
  a_fast: assert property (p_fast) else $error("fast filter not applied");
  // pin flop plus the pipe: the delay adds SIGNAL_OUTPUT_PIN_DLY to the plain one-cycle path
  property p_sig_dly;
    dly_age_r > 10'(SIGNAL_OUTPUT_PIN_DLY + 1) |-> signal_output_pin == $past(sig_out_src, SIGNAL_OUTPUT_PIN_DLY + 1);
  endproperty
  a_sig_dly: assert property (p_sig_dly) else $error("signal_output_pin delay wrong");
  property p_sig_nodly;
    !$past(rmt_r[5]) |-> signal_output_pin == $past(sig_out_src);
  endproperty
  a_sig_nodly: assert property (p_sig_nodly) else $error("signal_output_pin delayed when off");
  property p_parity_pll;
    wr_rmt ##1 !wr_rmt |=> parity_off == rmt_r[4] && wide_recovery_pll == rmt_r[3];
  endproperty
  a_parity_pll: assert property (p_parity_pll) else $error("parity or pll wrong");
  property p_corner;
    ##1 highpass_corner_frequency == ($past(rmt_r[2]) ? $past(rmt_r[1:0])
                                                      : $past(rx_speed_code));
  endproperty
  a_corner: assert property (p_corner) else $error("corner select wrong");
  property p_sof_drop;
    rx_state_r == rtb_pkg::RTB_RX_IDLE && rx_begin && sof_req && !rx_has_sof
      |=> rx_state_r == rtb_pkg::RTB_RX_DROP && irq_stat_r[0];
  endproperty
  a_sof_drop: assert property (p_sof_drop) else $error("stream without sof kept");
  property p_drop_quiet;
    rx_state_r == rtb_pkg::RTB_RX_DROP |=> !fifo_wr;
  endproperty
  a_drop_quiet: assert property (p_drop_quiet) else $error("dropped data stored");
  property p_sof_opt;
    rx_state_r == rtb_pkg::RTB_RX_IDLE && rx_begin && !sof_req
      |=> rx_state_r == rtb_pkg::RTB_RX_DATA;
  endproperty
  a_sof_opt: assert property (p_sof_opt) else $error("stream refused");
  property p_eof_err;
    rx_state_r == rtb_pkg::RTB_RX_DATA && rx_finish && eof_req && !rx_has_eof
      |=> irq_stat_r[1];
  endproperty
  a_eof_err: assert property (p_eof_err) else $error("missing eof not flagged");
  property p_eof_opt;
    !eof_req |-> !perr_evt;
  endproperty
  a_eof_opt: assert property (p_eof_opt) else $error("error without eof check");
  property p_rsv;
    rd_act && ap_map_r && (ap_idx_r == rtb_pkg::RMT_IDX || ap_idx_r == rtb_pkg::TBF_IDX)
      |=> hrdata[31:8] == 24'h000000 && (hrdata[7] == 1'b0 || ap_idx_r != rtb_pkg::RMT_IDX)
      && (hrdata[5] == 1'b0 || ap_idx_r != rtb_pkg::TBF_IDX);
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit not zero");
  property p_bus;
    addr_take |=> !hreadyout ##1 hreadyout;
  endproperty
  a_bus: assert property (p_bus) else $error("wait state wrong");
  property p_irq;
    ##1 irq == |($past(irq_stat_r) & $past(irq_mask_r));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");
endmodule // rtb_top

//--- verif/rtb_host.sv
// rtb_host: ahb-lite master standing in for the host controller.
// assumes one slave whose hreadyout is the bus hready.
`timescale 1ns/100ps
module rtb_host (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // released address and data lines show inverted junk, never the last value
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~a;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
    hwdata <= ~d;
  endtask
endmodule // rtb_host

//--- verif/receiver_tuning_and_typeb_framing_cfg_tb.sv
// receiver_tuning_and_typeb_framing_cfg_tb: random register and rx stream checks.
// assumes rtb_host drives the bus; signal_output_pin delay shortened to 4 cycles.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %s exp %0h got %0h", nm, e, g); end end
module receiver_tuning_and_typeb_framing_cfg_tb;
  localparam int DLY = 4;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, adj, drop;
  logic [31:0] haddr, hwdata, hrdata, r, q;
  logic [1:0] htrans, rx_speed_code, highpass_corner_frequency, tx_extra_guard_time;
  logic [2:0] hsize, st;
  logic rx_begin, rx_has_sof, rx_byte_valid, rx_finish, rx_has_eof, sig_out_src;
  logic [7:0] rx_byte, fifo_data, lastb, v, f, hist;
  logic miller_filter_fast, signal_output_pin_delay_enable, parity_off, wide_recovery_pll;
  logic signal_output_pin, fifo_wr, tx_start_frame_en, tx_end_frame_en;
  logic [11:0] sof_low_fc, sof_high_fc, eof_low_fc;
  logic [31:0] seed = 32'h00012ED9;
  int n_mismatch, total_checks, nwr, nwr0, cyc;

  rtb_host host_u (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  rtb_top #(.SIGNAL_OUTPUT_PIN_DLY(DLY)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .rx_speed_code(rx_speed_code), .rx_begin(rx_begin), .rx_has_sof(rx_has_sof),
    .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_finish(rx_finish),
    .rx_has_eof(rx_has_eof), .sig_out_src(sig_out_src),
    .miller_filter_fast(miller_filter_fast), .signal_output_pin_delay_enable(signal_output_pin_delay_enable),
    .parity_off(parity_off), .wide_recovery_pll(wide_recovery_pll),
    .highpass_corner_frequency(highpass_corner_frequency),
    .signal_output_pin(signal_output_pin), .fifo_wr(fifo_wr), .fifo_data(fifo_data),
    .sof_low_fc(sof_low_fc), .sof_high_fc(sof_high_fc), .eof_low_fc(eof_low_fc),
    .tx_start_frame_en(tx_start_frame_en), .tx_end_frame_en(tx_end_frame_en),
    .tx_extra_guard_time(tx_extra_guard_time), .irq(irq));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // etu is 128 carrier cycles
  function automatic logic [11:0] dlen(input logic w, input logic a, input logic hi);
    if (hi) return (w & a) ? 12'h108 : w ? 12'h180 : 12'h100;
    return (w & a) ? 12'h578 : w ? 12'h580 : 12'h500;
  endfunction
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [7:0] e);
    host_u.xfer(1'b0, a, 32'h0, q);
    `CHK("rdata", {24'h0, e}, q)
    `CHK("hresp", 1'b0, hresp)
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    hist <= {hist[6:0], sig_out_src};
    cyc++;
    if (fifo_wr === 1'b1) begin
      nwr++;
      lastb = fifo_data;
    end
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  initial begin
    {hresetn, rx_begin, rx_has_sof, rx_byte_valid, rx_finish, rx_has_eof} = 6'h00;
    {sig_out_src, rx_speed_code, rx_byte} = 11'h000;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(32'h74, 8'h00);
    rdc(32'h78, 8'h00);
    wr(32'h100, 32'hFF);
    rdc(32'h100, 8'h00);
    for (int i = 0; i < 12; i++) begin
      r = rnd();
      v = (i == 0) ? 8'hFF : r[15:8];
      f = (i == 1) ? 8'hDF : r[23:16];
      adj = f[4] & r[0];
      // adjust off first, so width never drops to 0 under it
      wr(32'h80, 32'h0);
      rx_speed_code <= r[2:1];
      wr(32'h74, {24'h0, v});
      wr(32'h78, {24'h0, f});
      wr(32'h80, {31'h0, adj});
      rdc(32'h74, v & 8'h7F);
      rdc(32'h78, f & 8'hDF);
      rdc(32'h80, {7'h00, adj});
      @(posedge hclk);
      #1;
      `CHK("fast", v[6], miller_filter_fast)
      `CHK("dly", v[5], signal_output_pin_delay_enable)
      `CHK("par", v[4], parity_off)
      `CHK("pll", v[3], wide_recovery_pll)
      `CHK("hpc", v[2] ? v[1:0] : rx_speed_code, highpass_corner_frequency)
      `CHK("sofen", ~f[3], tx_start_frame_en)
      `CHK("eofen", ~f[2], tx_end_frame_en)
      `CHK("egt", f[1:0], tx_extra_guard_time)
      `CHK("soflo", dlen(f[4], adj, 1'b0), sof_low_fc)
      `CHK("sofhi", dlen(f[4], adj, 1'b1), sof_high_fc)
      `CHK("eoflo", dlen(f[4], adj, 1'b0), eof_low_fc)
      repeat (10) begin
        r = rnd();
        @(posedge hclk);
        sig_out_src <= r[0];
        #1;
        `CHK("signal_output_pin", v[5] ? hist[DLY] : hist[0], signal_output_pin)
      end
    end
    for (int i = 0; i < 12; i++) begin
      r = rnd();
      // width kept at 1, adjust may still be set from above
      wr(32'h78, {24'h0, r[1:0], 6'h10});
      wr(32'h88, {29'h0, r[4:2]});
      nwr0 = nwr;
      rx_begin <= 1'b1;
      rx_has_sof <= r[5];
      @(posedge hclk);
      rx_begin <= 1'b0;
      for (int b = 0; b < 3; b++) begin
        rx_byte_valid <= 1'b1;
        rx_byte <= r[15:8] + 8'(b);
        @(posedge hclk);
      end
      rx_byte_valid <= 1'b0;
      rx_finish <= 1'b1;
      rx_has_eof <= r[6];
      @(posedge hclk);
      rx_finish <= 1'b0;
      repeat (2) @(posedge hclk);
      #1;
      drop = r[1] & ~r[5];
      st = drop ? 3'h1 : (r[0] & ~r[6]) ? 3'h2 : 3'h4;
      `CHK("nwr", drop ? 32'h0 : 32'h3, nwr - nwr0)
      if (!drop) `CHK("fifo", r[15:8] + 8'h02, lastb)
      `CHK("irq", |(st & r[4:2]), irq)
      rdc(32'h84, {5'h0, st});
      rdc(32'h8C, 8'h00);
      wr(32'h84, 32'h7);
      @(posedge hclk);
      #1;
      `CHK("irqclr", 1'b0, irq)
    end
    wrap_up();
  end
endmodule // receiver_tuning_and_typeb_framing_cfg_tb
